// ### hdl/pmes_bm_detect.sv
// Bus-master break detector: folds every activity source into one registered level.
`timescale 1ns/1ps
`default_nettype none

module pmes_bm_detect
    import pmes_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire pmes_bm_src_t src_i,
    output logic bm_break_o
);

    // A controller counts only when awake, running and with a live port.
    function automatic logic usb_active(input pmes_usb_t u);
        usb_active = !u.global_suspend && !(&u.port_suspended) && u.run; // [RL7]
    endfunction : usb_active

    logic [USB_CTRL_N-1:0] usb_act;

    genvar g;
    generate
        for (g = 0; g < USB_CTRL_N; g++) begin : g_usb
            assign usb_act[g] = usb_active(src_i.usb[g]);
        end
    endgenerate

    logic activity;
    assign activity = (|src_i.pci_req) || (|src_i.int_req) || src_i.gfx_busy
        || (|usb_act); // [RL6]

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            bm_break_o <= 1'b0;
        end else begin
            bm_break_o <= (|src_i.pci_irq) || activity || src_i.ide_start; // [RL5] [RL8]
        end
    end

endmodule : pmes_bm_detect
`default_nettype wire

// ### hdl/pmes_pkg.sv
// Shared constants and carrier types for the power-management event status low byte.
package pmes_pkg;

    // Status byte layout.
    localparam int STS_W = 8;
    localparam int TW_BIT = 0;
    localparam int BMB_BIT = 4;
    localparam int FA_BIT = 5;
    localparam logic [STS_W-1:0] STS_RESET = 8'h00;
    // Implemented bits per variant; everything else reads zero.
    localparam logic [STS_W-1:0] STS_MASK_MOBILE = 8'h31;
    localparam logic [STS_W-1:0] STS_MASK_DESKTOP = 8'h21;

    // Free-running timer.
    localparam int TMR_W = 24;
    localparam int TMR_WATCH_BIT = 22;
    localparam logic [TMR_W-1:0] TMR_RESET = 24'h000000;

    // Timing: core clock rate and the wrap interval in seconds, as printed.
    localparam int unsigned CLK_HZ = 200000000;
    localparam real TIMER_WRAP_S = 2.3435;
    // The watched bit rises once every 2^(TMR_WATCH_BIT+1) timer ticks.
    localparam real TICKS_PER_WRAP = 2.0 ** (TMR_WATCH_BIT + 1);
    localparam int unsigned TICK_HZ = int'(TICKS_PER_WRAP / TIMER_WRAP_S);
    // Wrap interval in core clock cycles, rounded down.
    localparam longint unsigned WRAP_CYCLES = longint'($floor(TIMER_WRAP_S * CLK_HZ));
    localparam int ACC_W = 32;

    // Bus-master sources.
    localparam int PCI_REQ_W = 6;
    localparam int PCI_IRQ_W = 8;
    localparam int INT_BM_W = 4;
    localparam int USB_CTRL_N = 2;
    localparam int USB_PORT_N = 2;

    typedef struct packed {
        logic global_suspend;
        logic [USB_PORT_N-1:0] port_suspended;
        logic run;
    } pmes_usb_t;

    // All break sources, active high, already in the core clock domain.
    typedef struct packed {
        logic [PCI_IRQ_W-1:0] pci_irq;
        logic [PCI_REQ_W-1:0] pci_req;
        logic [INT_BM_W-1:0] int_req;
        logic gfx_busy;
        pmes_usb_t [USB_CTRL_N-1:0] usb;
        logic ide_start;
    } pmes_bm_src_t;

endpackage : pmes_pkg

// ### hdl/pmes_status.sv
// Power-management event status low byte: flags, write-1-clear port and interrupt routing.
//
// Summary of operation
// RL1 - Firmware-attention flag, bit 5, sets when firmware asks for the handler.
// RL2 - Firmware release write raises a system-control interrupt and sets firmware-attention.
// RL3 - Writing 1 clears firmware-attention; writing 0 leaves it alone.
// RL4 - Mobile variant: bus-master-break flag, bit 4, sets on deep-idle break request.
// RL5 - Break events: any PCI interrupt line or internal bus-master activity.
// RL6 - Activity: PCI request, internal request, graphics busy, or active USB controller.
// RL7 - USB active: not globally suspended, a port awake, and run bit set.
// RL8 - IDE bus-master controller with start bit set also sets bus-master-break.
// RL9 - Writing 1 clears bus-master-break; writing 0 has no effect.
// RL10 - Timer-wrap flag, bit 0, sets on each rise of timer bit 22.
// RL11 - Timer-wrap flag sets periodically, every 2.3435 seconds.
// RL12 - With timer-wrap enable, flag raises system-control or management-mode interrupt.
// RL13 - Writing 1 clears timer-wrap; the handler issues that write.
// RL14 - Routing bit set gives system-control interrupt, clear gives management-mode interrupt.
// RL15 - Firmware-attention never makes management-mode interrupt; no flag here makes wake.
// RL16 - System-control interrupt while firmware-attention flag and its enable are set.
// RL17 - Timer-wrap enable clear gives no interrupt; set, routing bit selects the type.
// RL18 - A set and a write-1 clear in one cycle leave the flag set.
// RL19 - Bits 7:6, 3:1, and bit 4 on non-mobile, read zero, ignore writes.
`timescale 1ns/1ps
`default_nettype none

module pmes_status
    import pmes_pkg::*;
#(
    parameter bit MOBILE_VARIANT = 1'b1,
    parameter int unsigned TICK_INC = TICK_HZ,
    parameter int unsigned TICK_MOD = CLK_HZ,
    parameter logic [TMR_W-1:0] TMR_INIT = TMR_RESET
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    // Status register I/O port.
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [STS_W-1:0] io_wdata_i,
    output logic [STS_W-1:0] io_rdata_o,
    output logic io_rvalid_o,
    // Loose control bits held elsewhere in the power-management block.
    input wire logic firmware_release_bit_i,
    input wire logic firmware_attention_enable_i,
    input wire logic timer_wrap_enable_i,
    input wire logic route_to_sys_control_irq_i,
    // Bus-master sources from pins, active low.
    input wire logic [PCI_REQ_W-1:0] pci_req_n_i,
    input wire logic [PCI_IRQ_W-1:0] pci_irq_line_n_i,
    input wire logic graphics_port_busy_n_i,
    // Bus-master sources from on-chip logic on this clock.
    input wire logic [INT_BM_W-1:0] int_bm_req_i,
    input wire pmes_usb_t [USB_CTRL_N-1:0] usb_status_i,
    input wire logic ide_bus_master_ctrl_start_i,
    // Interrupt outputs and timer value.
    output logic sys_control_irq_o,
    output logic mgmt_mode_irq_o,
    output logic [TMR_W-1:0] timer_value_o
);

    localparam logic [STS_W-1:0] STS_MASK = MOBILE_VARIANT ? STS_MASK_MOBILE : STS_MASK_DESKTOP;
    localparam int PIN_W = PCI_REQ_W + PCI_IRQ_W + 1;

    // ------------------------------------------------------------------
    // Pin synchronisers. The first stage feeds only the second stage, so a
    // metastable sample never reaches the activity decode.
    // ------------------------------------------------------------------
    logic [PIN_W-1:0] pin_raw_n;
    logic [PIN_W-1:0] pin_meta_q;
    logic [PIN_W-1:0] pin_sync_q;

    assign pin_raw_n = {pci_req_n_i, pci_irq_line_n_i, graphics_port_busy_n_i};

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            pin_meta_q <= {PIN_W{1'b1}};
            pin_sync_q <= {PIN_W{1'b1}};
        end else begin
            pin_meta_q <= pin_raw_n;
            pin_sync_q <= pin_meta_q;
        end
    end

    // ------------------------------------------------------------------
    // Bus-master break detection.
    // ------------------------------------------------------------------
    pmes_bm_src_t bm_src;
    logic bm_break;

    always_comb begin
        bm_src = '0;
        bm_src.pci_req = ~pin_sync_q[PIN_W-1 -: PCI_REQ_W];
        bm_src.pci_irq = ~pin_sync_q[PCI_IRQ_W:1];
        bm_src.gfx_busy = ~pin_sync_q[0];
        bm_src.int_req = int_bm_req_i;
        bm_src.usb = usb_status_i;
        bm_src.ide_start = ide_bus_master_ctrl_start_i;
    end

    pmes_bm_detect u_bm_detect (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .src_i(bm_src),
        .bm_break_o(bm_break)
    );

    // ------------------------------------------------------------------
    // Free-running timer.
    // ------------------------------------------------------------------
    logic timer_wrap;

    pmes_wrap_timer #(
        .TICK_INC(TICK_INC),
        .TICK_MOD(TICK_MOD),
        .TMR_INIT(TMR_INIT)
    ) u_wrap_timer (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .timer_o(timer_value_o),
        .wrap_o(timer_wrap)
    );

    // ------------------------------------------------------------------
    // Firmware release. A one-cycle pulse from on-chip logic on this clock.
    // ------------------------------------------------------------------
    logic fw_release_q;

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            fw_release_q <= 1'b0;
        end else begin
            fw_release_q <= firmware_release_bit_i;
        end
    end

    // ------------------------------------------------------------------
    // Write-1-clear decode. Only implemented bits can be cleared.
    // ------------------------------------------------------------------
    logic [STS_W-1:0] clr_req;

    assign clr_req = io_wr_i ? (io_wdata_i & STS_MASK) : '0; // [RL19]

    // ------------------------------------------------------------------
    // Status flags. Hardware set is tested before the clear so that an
    // event landing on a write-1 never disappears.
    // ------------------------------------------------------------------
    logic firmware_attention_flag_q;
    logic bus_master_break_flag_q;
    logic timer_wrap_flag_q;

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            firmware_attention_flag_q <= STS_RESET[FA_BIT];
        end else if (firmware_release_bit_i) begin
            firmware_attention_flag_q <= 1'b1; // [RL1] [RL2] [RL18]
        end else if (clr_req[FA_BIT]) begin
            firmware_attention_flag_q <= 1'b0; // [RL3]
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            bus_master_break_flag_q <= STS_RESET[BMB_BIT];
        end else if (!MOBILE_VARIANT) begin
            bus_master_break_flag_q <= 1'b0; // [RL19]
        end else if (bm_break) begin
            bus_master_break_flag_q <= 1'b1; // [RL4] [RL18]
        end else if (clr_req[BMB_BIT]) begin
            bus_master_break_flag_q <= 1'b0; // [RL9]
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            timer_wrap_flag_q <= STS_RESET[TW_BIT];
        end else if (timer_wrap) begin
            timer_wrap_flag_q <= 1'b1; // [RL10] [RL18]
        end else if (clr_req[TW_BIT]) begin
            timer_wrap_flag_q <= 1'b0; // [RL13]
        end
    end

    logic [STS_W-1:0] status;

    always_comb begin
        status = STS_RESET;
        status[FA_BIT] = firmware_attention_flag_q;
        status[BMB_BIT] = bus_master_break_flag_q;
        status[TW_BIT] = timer_wrap_flag_q;
        status = status & STS_MASK; // [RL19]
    end

    // ------------------------------------------------------------------
    // Read port. Data are captured on the read strobe and answered one
    // cycle later, so a read never sees a half-updated byte.
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            io_rdata_o <= STS_RESET;
            io_rvalid_o <= 1'b0;
        end else begin
            io_rvalid_o <= io_rd_i;
            if (io_rd_i) begin
                io_rdata_o <= status;
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupt routing. Both outputs are levels that follow the flags;
    // the release pulse adds one extra cycle of system-control interrupt
    // even while the global enable is clear. None of these flags feeds a
    // wake path, which lives in the upper byte.
    // ------------------------------------------------------------------
    logic tw_irq;
    logic sci_d;
    logic smi_d;

    assign tw_irq = timer_wrap_flag_q && timer_wrap_enable_i; // [RL12] [RL17]
    assign sci_d = (firmware_attention_flag_q && firmware_attention_enable_i) // [RL16]
        || fw_release_q // [RL2]
        || (tw_irq && route_to_sys_control_irq_i); // [RL14]
    assign smi_d = tw_irq && !route_to_sys_control_irq_i; // [RL14] [RL15]

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            sys_control_irq_o <= 1'b0;
            mgmt_mode_irq_o <= 1'b0;
        end else begin
            sys_control_irq_o <= sci_d;
            mgmt_mode_irq_o <= smi_d;
        end
    end

endmodule : pmes_status
`default_nettype wire

// ### hdl/pmes_wrap_timer.sv
// Free-running 24-bit timer with a pulse on each rise of its watched bit.
`timescale 1ns/1ps
`default_nettype none

module pmes_wrap_timer
    import pmes_pkg::*;
#(
    parameter int unsigned TICK_INC = TICK_HZ,
    parameter int unsigned TICK_MOD = CLK_HZ,
    // Hardware keeps the reset value; a bench may start the timer near a rise of the
    // watched bit, since a full wrap takes millions of cycles.
    parameter logic [TMR_W-1:0] TMR_INIT = TMR_RESET
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    output logic [TMR_W-1:0] timer_o,
    output logic wrap_o
);

    // A phase accumulator gives the exact average tick rate, since the core
    // clock is not an integer multiple of it; the cost is one cycle of jitter.
    logic [ACC_W-1:0] acc_q;
    logic [ACC_W:0] acc_sum;
    logic tick;

    assign acc_sum = {1'b0, acc_q} + ACC_W'(TICK_INC);
    assign tick = acc_sum >= (ACC_W+1)'(TICK_MOD);

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            acc_q <= '0;
        end else if (tick) begin
            acc_q <= ACC_W'(acc_sum - (ACC_W+1)'(TICK_MOD));
        end else begin
            acc_q <= acc_sum[ACC_W-1:0];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            timer_o <= TMR_INIT;
        end else if (tick) begin
            timer_o <= timer_o + 24'h000001;
        end
    end

    logic watch_q;

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            watch_q <= TMR_INIT[TMR_WATCH_BIT];
            wrap_o <= 1'b0;
        end else begin
            watch_q <= timer_o[TMR_WATCH_BIT];
            wrap_o <= timer_o[TMR_WATCH_BIT] && !watch_q; // [RL10] [RL11]
        end
    end

endmodule : pmes_wrap_timer
`default_nettype wire

// ### testbench/pmes_status_props.sv
// Concurrent checks on the ports of the status low byte block.
`timescale 1ns/1ps
`default_nettype none

module pmes_status_props
    import pmes_pkg::*;
#(
    parameter bit MOBILE_VARIANT = 1'b1
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [STS_W-1:0] io_wdata_i,
    input wire logic [STS_W-1:0] io_rdata_o,
    input wire logic io_rvalid_o,
    input wire logic firmware_release_bit_i,
    input wire logic firmware_attention_enable_i,
    input wire logic timer_wrap_enable_i,
    input wire logic route_to_sys_control_irq_i,
    input wire logic [INT_BM_W-1:0] int_bm_req_i,
    input wire logic sys_control_irq_o,
    input wire logic mgmt_mode_irq_o,
    input wire logic [TMR_W-1:0] timer_value_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (srst_i);

    property p_rvalid;
        io_rd_i |=> io_rvalid_o;
    endproperty
    a_rvalid: assert property (p_rvalid) else $error("read not answered");
    property p_no_rvalid;
        !io_rd_i |=> !io_rvalid_o;
    endproperty
    a_no_rvalid: assert property (p_no_rvalid) else $error("spurious read answer");
    property p_rsvd;
        io_rvalid_o |-> io_rdata_o[7:6] == 2'h0 && io_rdata_o[3:1] == 3'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
    property p_rel_sci;
        firmware_release_bit_i |-> ##2 sys_control_irq_o;
    endproperty
    a_rel_sci: assert property (p_rel_sci) else $error("release gave no interrupt");
    property p_rel_flag;
        firmware_release_bit_i ##1 io_rd_i |=> io_rdata_o[FA_BIT];
    endproperty
    a_rel_flag: assert property (p_rel_flag) else $error("release did not set flag");
    property p_fa_clear;
        io_wr_i && io_wdata_i[FA_BIT] && !firmware_release_bit_i ##1 io_rd_i
            |=> !io_rdata_o[FA_BIT];
    endproperty
    a_fa_clear: assert property (p_fa_clear) else $error("attention flag not cleared");
    property p_fa_sci;
        firmware_release_bit_i ##1 (firmware_attention_enable_i && !io_wr_i) [*3]
            |=> sys_control_irq_o;
    endproperty
    a_fa_sci: assert property (p_fa_sci) else $error("enabled flag gave no interrupt");
    property p_mgmt_src;
        mgmt_mode_irq_o |-> $past(timer_wrap_enable_i) && !$past(route_to_sys_control_irq_i);
    endproperty
    a_mgmt_src: assert property (p_mgmt_src) else $error("unexpected mgmt interrupt");
    property p_bm_set;
        (|int_bm_req_i) [*3] ##0 io_rd_i |=> io_rdata_o[BMB_BIT] == MOBILE_VARIANT;
    endproperty
    a_bm_set: assert property (p_bm_set) else $error("break flag wrong");
    property p_wrap_sci;
        $rose(timer_value_o[TMR_WATCH_BIT]) ##0
            (timer_wrap_enable_i && route_to_sys_control_irq_i && !io_wr_i) [*4]
            |=> sys_control_irq_o;
    endproperty
    a_wrap_sci: assert property (p_wrap_sci) else $error("timer wrap gave no interrupt");

    c_release: cover property (firmware_release_bit_i ##2 sys_control_irq_o);
    c_read: cover property (io_rd_i ##1 io_rvalid_o);
    c_bm: cover property ((|int_bm_req_i) ##3 io_rvalid_o && io_rdata_o[BMB_BIT]);
endmodule : pmes_status_props

bind pmes_status pmes_status_props #(.MOBILE_VARIANT(MOBILE_VARIANT)) props_u (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
    .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o), .io_rvalid_o(io_rvalid_o),
    .firmware_release_bit_i(firmware_release_bit_i),
    .firmware_attention_enable_i(firmware_attention_enable_i),
    .timer_wrap_enable_i(timer_wrap_enable_i),
    .route_to_sys_control_irq_i(route_to_sys_control_irq_i),
    .int_bm_req_i(int_bm_req_i), .sys_control_irq_o(sys_control_irq_o),
    .mgmt_mode_irq_o(mgmt_mode_irq_o), .timer_value_o(timer_value_o));
`default_nettype wire

// ### testbench/pmes_status_test.sv
// Self-checking testbench for the status low byte block.
`timescale 1ns/1ps
`default_nettype none

module pmes_status_test
    import pmes_pkg::*;
;
    logic ref_clk_i = 1'b0, srst_i = 1'b1, io_wr_i = 1'b0, io_rd_i = 1'b0;
    logic [STS_W-1:0] io_wdata_i = 8'h00;
    logic [STS_W-1:0] io_rdata_o;
    logic io_rvalid_o, sys_control_irq_o, mgmt_mode_irq_o;
    logic rel = 1'b0, fa_en = 1'b0, tw_en = 1'b1, route = 1'b0, gfx_n = 1'b1, ide = 1'b0;
    logic [PCI_REQ_W-1:0] req_n = 6'h3f;
    logic [PCI_IRQ_W-1:0] irq_n = 8'hff;
    logic [INT_BM_W-1:0] int_bm_req_i = 4'h0;
    // Idle USB: globally suspended, ports suspended, run clear.
    pmes_usb_t [USB_CTRL_N-1:0] usb = {4'he, 4'he};
    logic [TMR_W-1:0] timer_value_o;
    logic [STS_W-1:0] desk_rdata;
    int failures = 0, tests_run = 0;
    // The watched timer bit rises 1024 cycles after reset, well after the other tests.
    localparam logic [TMR_W-1:0] TMR_START = 24'h3ffc00;

    // Tick every core cycle so the timer runs as fast as possible.
    pmes_status #(.MOBILE_VARIANT(1'b1), .TICK_INC(CLK_HZ), .TICK_MOD(CLK_HZ),
        .TMR_INIT(TMR_START)) dut_u (
        .ref_clk_i(ref_clk_i), .srst_i(srst_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
        .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o), .io_rvalid_o(io_rvalid_o),
        .firmware_release_bit_i(rel), .firmware_attention_enable_i(fa_en),
        .timer_wrap_enable_i(tw_en), .route_to_sys_control_irq_i(route),
        .pci_req_n_i(req_n), .pci_irq_line_n_i(irq_n), .graphics_port_busy_n_i(gfx_n),
        .int_bm_req_i(int_bm_req_i), .usb_status_i(usb), .ide_bus_master_ctrl_start_i(ide),
        .sys_control_irq_o(sys_control_irq_o), .mgmt_mode_irq_o(mgmt_mode_irq_o),
        .timer_value_o(timer_value_o));

    // The same stimulus into the non-mobile variant, which has no break flag.
    pmes_status #(.MOBILE_VARIANT(1'b0), .TICK_INC(CLK_HZ), .TICK_MOD(CLK_HZ),
        .TMR_INIT(TMR_START)) desk_u (
        .ref_clk_i(ref_clk_i), .srst_i(srst_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
        .io_wdata_i(io_wdata_i), .io_rdata_o(desk_rdata), .io_rvalid_o(),
        .firmware_release_bit_i(rel), .firmware_attention_enable_i(fa_en),
        .timer_wrap_enable_i(tw_en), .route_to_sys_control_irq_i(route),
        .pci_req_n_i(req_n), .pci_irq_line_n_i(irq_n), .graphics_port_busy_n_i(gfx_n),
        .int_bm_req_i(int_bm_req_i), .usb_status_i(usb), .ide_bus_master_ctrl_start_i(ide),
        .sys_control_irq_o(), .mgmt_mode_irq_o(), .timer_value_o());

    initial begin
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask : cyc

    task automatic rd(input string nm, input logic [7:0] exp);
        @(posedge ref_clk_i) io_rd_i <= 1'b1;
        @(posedge ref_clk_i) io_rd_i <= 1'b0;
        #1 chk(nm, exp, io_rdata_o);
        chk("rvalid", 8'h01, {7'h00, io_rvalid_o});
    endtask : rd

    task automatic wr(input logic [7:0] d);
        @(posedge ref_clk_i) begin
            io_wr_i <= 1'b1;
            io_wdata_i <= d;
        end
        @(posedge ref_clk_i) io_wr_i <= 1'b0;
    endtask : wr

    task automatic irqs(input string nm, input logic [7:0] exp);
        @(posedge ref_clk_i) #1 chk(nm, exp, {6'h00, mgmt_mode_irq_o, sys_control_irq_o});
    endtask : irqs

    // Sources 0..6 are break events; 7..9 are USB states that must not count.
    task automatic set_src(input int k, input bit on);
        @(posedge ref_clk_i) case (k)
            0: req_n <= on ? 6'h3e : 6'h3f;
            1: irq_n <= on ? 8'h7f : 8'hff;
            2: gfx_n <= !on;
            3: int_bm_req_i <= on ? 4'h8 : 4'h0;
            4: usb[0] <= on ? 4'h5 : 4'he;
            5: usb[1] <= on ? 4'h3 : 4'he;
            6: ide <= on;
            7: usb[0] <= on ? 4'h9 : 4'he;
            8: usb[0] <= on ? 4'h7 : 4'he;
            default: usb[0] <= on ? 4'h4 : 4'he;
        endcase
    endtask : set_src

    initial begin
        #50000;
        failures++;
        tally_and_finish();
    end

    initial begin
        cyc(5);
        srst_i <= 1'b0;
        rd("reset_value", 8'h00);
        $display("test reset done");

        @(posedge ref_clk_i) rel <= 1'b1;
        @(posedge ref_clk_i) rel <= 1'b0;
        irqs("release_pulse", 8'h01);
        irqs("pulse_ends", 8'h00);
        rd("release_flag", 8'h20);
        wr(8'h00);
        rd("write_zero", 8'h20);
        @(posedge ref_clk_i) fa_en <= 1'b1;
        cyc(1);
        irqs("enabled_flag", 8'h01);
        wr(8'h20);
        rd("fa_clear", 8'h00);
        irqs("sci_drops", 8'h00);
        @(posedge ref_clk_i) fa_en <= 1'b0;
        $display("test attention done");

        wr(8'hce);
        rd("reserved", 8'h00);
        $display("test reserved done");

        for (int k = 0; k < 10; k++) begin
            set_src(k, 1'b1);
            cyc(4);
            set_src(k, 1'b0);
            cyc(4);
            rd("bm_flag", (k < 7) ? 8'h10 : 8'h00);
            chk("bm_flag_desk", 8'h00, desk_rdata);
            wr(8'h10);
            rd("bm_clear", 8'h00);
        end
        $display("test bus master done");

        set_src(3, 1'b1);
        cyc(3);
        wr(8'h10);
        rd("bm_set_wins", 8'h10);
        set_src(3, 1'b0);
        cyc(4);
        @(posedge ref_clk_i) begin
            rel <= 1'b1;
            io_wr_i <= 1'b1;
            io_wdata_i <= 8'h20;
        end
        @(posedge ref_clk_i) begin
            rel <= 1'b0;
            io_wr_i <= 1'b0;
        end
        rd("fa_set_wins", 8'h30);
        wr(8'h30);
        rd("all_clear", 8'h00);
        // No wrap happens this early, so the enabled timer path stays quiet.
        irqs("no_timer_irq", 8'h00);
        $display("test collisions done");

        @(posedge ref_clk_i) route <= 1'b1;
        while (!timer_value_o[TMR_WATCH_BIT]) begin
            @(posedge ref_clk_i);
            #1;
        end
        cyc(2);
        irqs("wrap_sci", 8'h01);
        rd("wrap_flag", 8'h01);
        @(posedge ref_clk_i) route <= 1'b0;
        irqs("wrap_smi", 8'h02);
        @(posedge ref_clk_i) tw_en <= 1'b0;
        irqs("wrap_masked", 8'h00);
        wr(8'h01);
        rd("wrap_clear", 8'h00);
        $display("test timer done");
        tally_and_finish();
    end
endmodule : pmes_status_test
`default_nettype wire
